// *** design/dlf_regs.sv ***
// Notes on behaviour
// - Acquisition bandwidth applies only while acquiring lock and when selection bit allows.
// - Three-bit secondary damping code; 001..101 valid, 011 default, others unused.
// - Gain field bits 6:4 applies only for low-rate analog feedback and enable bit.
// - Secondary damping register is read/write and resets to 0x13.
//
// The implementer's own choice: register access over AXI4-Lite.
`include "dlf_consts.svh"
module dlf_regs (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  // AXI4-Lite write
  input  wire logic [9:0]        s_awaddr_in,
  input  wire logic              s_awvalid_in,
  output logic                   s_awready_out,
  input  wire logic [31:0]       s_wdata_in,
  input  wire logic [3:0]        s_wstrb_in,
  input  wire logic              s_wvalid_in,
  output logic                   s_wready_out,
  output logic [1:0]             s_bresp_out,
  output logic                   s_bvalid_out,
  input  wire logic              s_bready_in,
  // AXI4-Lite read
  input  wire logic [9:0]        s_araddr_in,
  input  wire logic              s_arvalid_in,
  output logic                   s_arready_out,
  output logic [31:0]            s_rdata_out,
  output logic [1:0]             s_rresp_out,
  output logic                   s_rvalid_out,
  input  wire logic              s_rready_in,
  // Loop status and enables from elsewhere in the device
  input  wire logic              main_acquiring_in,
  input  wire logic              acq_bw_select_in,
  input  wire logic              low_freq_analog_in,
  input  wire logic              pd_gain_enable_in,
  // Settings to the loop filters
  output dlf_pkg::dlf_loop_cfg_type loop_cfg_out
);

  dlf_pkg::dlf_state_type s_q;
  dlf_pkg::dlf_state_type s_d;

  // Byte address to register index
  function automatic logic [7:0] word_idx(input logic [9:0] a);
    word_idx = a[9:2];
  endfunction : word_idx

  // Next-state logic for the whole bank
  always_comb begin
    s_d = s_q;
    if (s_awvalid_in && s_awready_out) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_awaddr_in;
    end
    if (s_wvalid_in && s_wready_out) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_wdata_in;
      s_d.wstrb = s_wstrb_in;
    end
    // Commit once both halves are held; new items wait until the response is taken
    case (s_q.wst)
      dlf_pkg::WR_IDLE: begin
        if (s_q.aw_got && s_q.w_got) begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.bresp  = `DLF_RESP_OKAY;
          s_d.wst    = dlf_pkg::WR_RESP;
          // Only byte lane 0 carries register data
          if (word_idx(s_q.awaddr) == `DLF_ACQ_BW_IDX) begin
            if (s_q.wstrb[0]) begin
              s_d.acq_reg = s_q.wdata[7:0] & `DLF_ACQ_BW_MASK;
            end
          end else if (word_idx(s_q.awaddr) == `DLF_DAMP_IDX) begin
            if (s_q.wstrb[0]) begin
              s_d.damp_reg = s_q.wdata[7:0] & `DLF_DAMP_MASK;
            end
          end else begin
            s_d.bresp = `DLF_RESP_SLVERR;
          end
        end
      end
      dlf_pkg::WR_RESP: begin
        if (s_bready_in) begin
          s_d.bvalid = 1'b0;
          s_d.wst    = dlf_pkg::WR_IDLE;
        end
      end
      default: begin
        s_d.wst = dlf_pkg::WR_IDLE;
      end
    endcase
    // Read path: one cycle after address accept
    if (s_q.rvalid && s_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (s_arvalid_in && s_arready_out) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `DLF_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (word_idx(s_araddr_in) == `DLF_ACQ_BW_IDX) begin
        s_d.rdata[7:0] = s_q.acq_reg;
      end else if (word_idx(s_araddr_in) == `DLF_DAMP_IDX) begin
        s_d.rdata[7:0] = s_q.damp_reg;
      end else begin
        s_d.rresp = `DLF_RESP_SLVERR;
      end
    end
    // Readies live in the state, so a taken item closes its channel on the next edge
    s_d.awready = !s_d.aw_got && s_d.wst == dlf_pkg::WR_IDLE;
    s_d.wready  = !s_d.w_got && s_d.wst == dlf_pkg::WR_IDLE;
    s_d.arready = !s_d.rvalid;
    // Decoded settings, registered from the stored fields
    s_d.cfg.acq_bw_code    = s_d.acq_reg[4:0];
    s_d.cfg.acq_bw_valid   = s_d.acq_reg[4:0] <= `DLF_ACQ_BW_MAX;
    s_d.cfg.acq_bw_active  = main_acquiring_in && acq_bw_select_in && s_d.cfg.acq_bw_valid;
    s_d.cfg.damping_code   = s_d.damp_reg[2:0];
    s_d.cfg.damping_valid  = s_d.damp_reg[2:0] >= `DLF_DAMP_MIN && s_d.damp_reg[2:0] <= `DLF_DAMP_MAX;
    s_d.cfg.pd_gain_code   = s_d.damp_reg[6:4];
    s_d.cfg.pd_gain_active = low_freq_analog_in && pd_gain_enable_in;
  end

  // State register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q          <= '0;
      s_q.acq_reg  <= `DLF_ACQ_BW_RESET;
      s_q.damp_reg <= `DLF_DAMP_RESET;
      s_q.wst      <= dlf_pkg::WR_IDLE;
      // Decoded defaults show during reset, so the loops never see all-zero codes
      s_q.cfg.acq_bw_code   <= 5'(`DLF_ACQ_BW_RESET);
      s_q.cfg.acq_bw_valid  <= 1'b1;
      s_q.cfg.damping_code  <= 3'(`DLF_DAMP_RESET);
      s_q.cfg.damping_valid <= 1'b1;
      s_q.cfg.pd_gain_code  <= 3'(`DLF_DAMP_RESET >> 4);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign s_awready_out = s_q.awready;
  assign s_wready_out  = s_q.wready;
  assign s_arready_out = s_q.arready;
  assign s_bvalid_out  = s_q.bvalid;
  assign s_bresp_out   = s_q.bresp;
  assign s_rvalid_out  = s_q.rvalid;
  assign s_rdata_out   = s_q.rdata;
  assign s_rresp_out   = s_q.rresp;
  assign loop_cfg_out  = s_q.cfg;

  // Unused bit positions never hold a one, whatever software wrote
  a_damp_reserved: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.damp_reg[7] == 1'b0 && s_q.damp_reg[3] == 1'b0)
    else $error("damping reserved bit set");
  a_acq_reserved: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.acq_reg[7:5] == 3'h0)
    else $error("acq reserved bits set");

  // A committed write with lane 0 set lands, masked, on the next edge
  a_damp_write: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.wst == dlf_pkg::WR_IDLE && s_q.aw_got && s_q.w_got && s_q.wstrb[0]
    && word_idx(s_q.awaddr) == `DLF_DAMP_IDX
    |=> s_q.damp_reg == ($past(s_q.wdata[7:0]) & `DLF_DAMP_MASK))
    else $error("damping write lost");
  a_acq_write: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.wst == dlf_pkg::WR_IDLE && s_q.aw_got && s_q.w_got && s_q.wstrb[0]
    && word_idx(s_q.awaddr) == `DLF_ACQ_BW_IDX
    |=> s_q.acq_reg == ($past(s_q.wdata[7:0]) & `DLF_ACQ_BW_MASK))
    else $error("acq write lost");

  // Lane 0 off or an unmapped address leaves both registers as they were
  a_lane_off: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.wst == dlf_pkg::WR_IDLE && s_q.aw_got && s_q.w_got && !s_q.wstrb[0]
    |=> $stable(s_q.acq_reg) && $stable(s_q.damp_reg))
    else $error("masked write changed a register");
  a_bad_addr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_q.wst == dlf_pkg::WR_IDLE && s_q.aw_got && s_q.w_got
    && word_idx(s_q.awaddr) != `DLF_ACQ_BW_IDX && word_idx(s_q.awaddr) != `DLF_DAMP_IDX
    |=> $stable(s_q.acq_reg) && $stable(s_q.damp_reg) && s_bresp_out == `DLF_RESP_SLVERR)
    else $error("unmapped write not refused");

  // Read data carry the stored byte with the upper bits at zero
  a_acq_read: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_arvalid_in && s_arready_out && word_idx(s_araddr_in) == `DLF_ACQ_BW_IDX
    |=> s_rdata_out == {24'h00_0000, $past(s_q.acq_reg)} && s_rresp_out == `DLF_RESP_OKAY)
    else $error("acq read data wrong");
  a_damp_read: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_arvalid_in && s_arready_out && word_idx(s_araddr_in) == `DLF_DAMP_IDX
    |=> s_rdata_out == {24'h00_0000, $past(s_q.damp_reg)} && s_rresp_out == `DLF_RESP_OKAY)
    else $error("damping read data wrong");

  // One transfer at a time each way; a channel stays shut while its answer waits
  a_write_busy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_bvalid_out |-> !s_awready_out && !s_wready_out)
    else $error("write accepted during response");
  a_read_busy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_rvalid_out |-> !s_arready_out)
    else $error("read accepted during response");
  a_read_once: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    s_arvalid_in && s_arready_out |=> s_rvalid_out && !s_arready_out)
    else $error("read not answered");

  // Decoded codes track the stored fields; validity follows the listed code ranges
  a_cfg_track: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.acq_bw_code == s_q.acq_reg[4:0] && loop_cfg_out.damping_code == s_q.damp_reg[2:0])
    else $error("settings out of step with registers");
  a_acq_valid: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.acq_bw_valid == (loop_cfg_out.acq_bw_code <= `DLF_ACQ_BW_MAX))
    else $error("acq code check wrong");
  a_damp_valid: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.damping_valid == (loop_cfg_out.damping_code inside {[`DLF_DAMP_MIN:`DLF_DAMP_MAX]}))
    else $error("damping code check wrong");
  a_gain_bits: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.pd_gain_code == s_q.damp_reg[6:4])
    else $error("gain field not bits 6:4");

  // Enables act one edge later, since the settings are registered
  a_acq_active: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.acq_bw_active |-> $past(main_acquiring_in) && $past(acq_bw_select_in))
    else $error("acq bw applied outside acquisition");
  a_acq_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.acq_bw_active |-> loop_cfg_out.acq_bw_valid)
    else $error("unused acq code applied");
  a_gain_field: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    loop_cfg_out.pd_gain_active |-> $past(low_freq_analog_in) && $past(pd_gain_enable_in))
    else $error("gain applied without enable");
endmodule : dlf_regs

// *** inc/dlf_consts.svh ***
`ifndef DLF_CONSTS_SVH
`define DLF_CONSTS_SVH
// Register indices; the bus byte address is four times the index
`define DLF_ACQ_BW_IDX      8'h69
`define DLF_DAMP_IDX        8'h6A
`define DLF_ADDR_W          10
`define DLF_ACQ_BW_RESET    8'h0F
`define DLF_DAMP_RESET      8'h13
`define DLF_ACQ_BW_MASK     8'h1F
`define DLF_DAMP_MASK       8'h77
`define DLF_ACQ_BW_MAX      5'h11
`define DLF_DAMP_MIN        3'h1
`define DLF_DAMP_MAX        3'h5
`define DLF_RESP_OKAY       2'h0
`define DLF_RESP_SLVERR     2'h2
`endif

// *** inc/dlf_pkg.sv ***
package dlf_pkg;
  // Write-side handshake state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } dlf_wr_state_type;

  // Loop settings handed to the filter logic
  typedef struct packed {
    logic [4:0] acq_bw_code;
    logic       acq_bw_valid;
    logic       acq_bw_active;
    logic [2:0] damping_code;
    logic       damping_valid;
    logic [2:0] pd_gain_code;
    logic       pd_gain_active;
  } dlf_loop_cfg_type;

  // Whole module state
  typedef struct packed {
    logic [7:0]   acq_reg;
    logic [7:0]   damp_reg;
    logic         aw_got;
    logic         w_got;
    logic [9:0]   awaddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    dlf_wr_state_type wst;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         awready;
    logic         wready;
    logic         arready;
    dlf_loop_cfg_type cfg;
  } dlf_state_type;
endpackage : dlf_pkg

// *** dv/dlf_regs_bench.sv ***
`include "dlf_consts.svh"
module dlf_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Bench-driven inputs, all defined at time zero
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [9:0]            awaddr = 10'h000;
  logic [9:0]            araddr = 10'h000;
  logic                  awvalid = 1'b0;
  logic                  wvalid = 1'b0;
  logic                  bready = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready = 1'b0;
  logic [31:0]           wdata = 32'h0;
  logic [3:0]            wstrb = 4'h0;
  logic                  acq = 1'b0;
  logic                  sel = 1'b0;
  logic                  lfa = 1'b0;
  logic                  pen = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  dlf_pkg::dlf_loop_cfg_type cfg;
  int                    mismatches = 0;
  int                    check_count = 0;
  // Index times four gives the byte address
  localparam logic [9:0] ACQ_A = 10'(`DLF_ACQ_BW_IDX) * 10'h4;
  localparam logic [9:0] DMP_A = 10'(`DLF_DAMP_IDX) * 10'h4;
  localparam logic [1:0] OK = `DLF_RESP_OKAY;
  localparam logic [1:0] ERR = `DLF_RESP_SLVERR;

  always #2.5 clk = ~clk;

  dlf_regs dut (.core_clk_in(clk), .sys_rst_in(rst), .s_awaddr_in(awaddr), .s_awvalid_in(awvalid),
    .s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(wstrb), .s_wvalid_in(wvalid),
    .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
    .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready), .s_rdata_out(rdata),
    .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready), .main_acquiring_in(acq),
    .acq_bw_select_in(sel), .low_freq_analog_in(lfa), .pd_gain_enable_in(pen), .loop_cfg_out(cfg));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask : wr

  // Read data is only meaningful on an OKAY answer
  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(32'(rresp), 32'(er));
    if (er == OK) check(rdata, ed);
  endtask : rd

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(cfg), 32'({5'h0F, 1'b1, 1'b0, 3'h3, 1'b1, 3'h1, 1'b0}));
    rd(ACQ_A, 32'h0F, OK);
    rd(DMP_A, 32'h13, OK);
    wr(ACQ_A, 32'hFFFF_FFFF, 4'hF, OK);
    rd(ACQ_A, 32'h1F, OK);
    wr(DMP_A, 32'hFFFF_FFFF, 4'hF, OK);
    rd(DMP_A, 32'h77, OK);
    wr(DMP_A, 32'h25, 4'h0, OK);
    rd(DMP_A, 32'h77, OK);
    wr(10'h1AC, 32'h25, 4'hF, ERR);
    rd(10'h1AC, 32'h0, ERR);
    rd(DMP_A, 32'h77, OK);
    // Every acquisition code, including the unused ones
    for (int i = 0; i < 32; i++) begin
      wr(ACQ_A, 32'(i), 4'hF, OK);
      check(32'({cfg.acq_bw_code, cfg.acq_bw_valid}), 32'({5'(i), i <= 17}));
    end
    // Every damping code with a mirrored gain code
    for (int i = 0; i < 8; i++) begin
      wr(DMP_A, {24'h0, 1'b0, 3'(7 - i), 1'b0, 3'(i)}, 4'hF, OK);
      check(32'({cfg.damping_code, cfg.damping_valid}), 32'({3'(i), i >= 1 && i <= 5}));
      check(32'(cfg.pd_gain_code), 32'(7 - i));
    end
    wr(ACQ_A, 32'h0A, 4'hF, OK);
    wr(DMP_A, 32'h13, 4'hF, OK);
    // All combinations of lock state and enables
    for (int j = 0; j < 16; j++) begin
      @(posedge clk);
      {pen, lfa, sel, acq} <= 4'(j);
      repeat (2) @(posedge clk);
      check(32'(cfg.acq_bw_active), 32'(j[0] & j[1]));
      check(32'(cfg.pd_gain_active), 32'(j[2] & j[3]));
    end
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #25000;
    mismatches++;
    stop_test();
  end
endmodule : dlf_regs_bench
